// ### design/dma_channel_control_regs.sv
// Four-channel DMA programming registers with AXI4-Lite access and per-unit stepping
//
// The address map and the AXI4-Lite slave port were left to the implementer.
`timescale 1ns/100ps
`default_nettype none

// Operation
// - Source pointer 32-bit RW, shows next source
// - Device-to-memory single mode ignores source pointer
// - Destination pointer 32-bit RW, shows next destination
// - Memory-to-device single mode ignores destination pointer
// - Count literal, zero means 65536 transfers
// - Count reads remaining units during transfer
// - Pointers and count need no reset value
// - Control cleared on reset and standby
// - Destination step: hold, increment, decrement by size
// - Destination step ignored memory-to-device single mode
// - Source step: hold, increment, decrement by size
// - Source step ignored device-to-memory single mode
// - External pin sources: dual, two single directions
// - Peripheral, auto and converter sources, dual mode
// - External sources only on channels 0, 1
// - Ack timing selects read or write cycle
// - Ack and detect bits writable channels 0,1
// - End flag ignores ones, cleared by zero
// - Ack timing zero read, one write cycle
// - End flag on count zero; blocks start
module dma_channel_control_regs #(
  parameter int NUM_CH = dma_chan_pkg::NUM_CH, // Channel count
  parameter int EXT_CH = dma_chan_pkg::EXT_CH // Channels with external pins
) (
  input wire logic ref_clk, // System clock
  input wire logic rst, // Asynchronous reset, active high
  input wire logic standby, // Standby entry, clears control
  input wire logic [dma_chan_pkg::ADDR_W-1:0] s_axi_awaddr, // Write address
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [31:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Write byte strobes
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  output logic [1:0] s_axi_bresp, // Write response
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [dma_chan_pkg::ADDR_W-1:0] s_axi_araddr, // Read address
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  output logic [31:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  output logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready, // Read data ready
  input wire logic global_dma_enable, // Shared enable from operation register
  input wire logic [1:0] ext_request_pin, // External request pins, channels 0 and 1
  input wire logic serial0_rx_full_req, // Serial 0 receive full
  input wire logic serial0_tx_empty_req, // Serial 0 transmit empty
  input wire logic serial1_rx_full_req, // Serial 1 receive full
  input wire logic serial1_tx_empty_req, // Serial 1 transmit empty
  input wire logic [3:0] timer_match_req, // Timer channel 0..3 match/capture
  input wire logic conversion_end_req, // Converter end
  input wire logic [NUM_CH-1:0] unitDone, // Pulse: one unit transferred
  input wire logic [1:0] readCycle, // Channel 0/1 bus read cycle in progress
  input wire logic [1:0] writeCycle, // Channel 0/1 bus write cycle in progress
  output logic [1:0] ext_acknowledge_pin, // Acknowledge pins, polarity applied
  output logic [NUM_CH-1:0] channelActive, // Enabled, not ended and global enable set
  output logic [NUM_CH-1:0] channelRequest, // Active with selected request present
  output logic [NUM_CH-1:0] singleAddr, // Single-address mode selected
  output logic [NUM_CH-1:0] burstMode, // Burst bus mode selected
  output logic [NUM_CH-1:0] wordSize, // Word transfer size selected
  output logic [NUM_CH-1:0] endIrq, // End flag with interrupt enable
  output logic [NUM_CH*32-1:0] srcPointers, // Source pointers, channel 0 lowest
  output logic [NUM_CH*32-1:0] dstPointers // Destination pointers, channel 0 lowest
);
  import dma_chan_pkg::*;

  // ****************************************************
  // Storage
  // ****************************************************
  logic [31:0] srcPtr [NUM_CH];
  logic [31:0] dstPtr [NUM_CH];
  logic [15:0] count [NUM_CH];
  logic [15:0] ctl [NUM_CH];
  logic [1:0] extPrev;
  logic [ADDR_W-1:0] wrAddr;
  logic [31:0] wrData;
  logic [3:0] wrStrb;
  logic haveAw;
  logic haveW;
  logic doWrite;
  logic [1:0] wrKind;
  logic [1:0] wrCh;
  logic wrHit;
  logic [1:0] rdKind;
  logic [1:0] rdCh;
  logic rdHit;

  // ****************************************************
  // Helpers
  // ****************************************************
  // Map a byte address to register kind, channel and hit
  function automatic logic [4:0] decode(input logic [ADDR_W-1:0] a);
    logic [4:0] res;
    logic [7:0] idx;
    res = 5'h00;
    idx = a[ADDR_W-1:2];
    for (int c = 0; c < NUM_CH; c++) begin
      if (idx == SRC_IDX + 8'(c) * CH_STRIDE) res = {1'b1, 2'(c), 2'd0};
      if (idx == DST_IDX + 8'(c) * CH_STRIDE) res = {1'b1, 2'(c), 2'd1};
      if (idx == CNT_IDX + 8'(c) * CH_STRIDE) res = {1'b1, 2'(c), 2'd2};
      if (idx == CTL_IDX + 8'(c) * CH_STRIDE) res = {1'b1, 2'(c), 2'd3};
    end
    if (a[1:0] != 2'b00) res = 5'h00;
    return res;
  endfunction

  // Merge write data into a word under the byte strobes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                         input logic [3:0] s);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (s[b]) r[b*8 +: 8] = d[b*8 +: 8];
    end
    return r;
  endfunction

  // Step a pointer by the transfer size; illegal code holds
  function automatic logic [31:0] stepPtr(input logic [31:0] p, input logic [1:0] mode,
                                           input logic word);
    logic [31:0] inc;
    inc = word ? 32'h0000_0002 : 32'h0000_0001;
    unique case (step_t'(mode))
      STEP_INC: return p + inc;
      STEP_DEC: return p - inc;
      STEP_HOLD: return p;
      STEP_BAD: return p;
    endcase
  endfunction

  // ****************************************************
  // Write channel handshake
  // ****************************************************
  assign s_axi_awready = !haveAw;
  assign s_axi_wready = !haveW;
  assign doWrite = haveAw && haveW && !s_axi_bvalid;
  assign {wrHit, wrCh, wrKind} = decode(wrAddr);

  // Latch address and data in either order
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      haveAw <= 1'b0;
      haveW <= 1'b0;
      wrAddr <= '0;
      wrData <= 32'h0000_0000;
      wrStrb <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        haveAw <= 1'b1;
        wrAddr <= s_axi_awaddr;
      end else if (doWrite) begin
        haveAw <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        haveW <= 1'b1;
        wrData <= s_axi_wdata;
        wrStrb <= s_axi_wstrb;
      end else if (doWrite) begin
        haveW <= 1'b0;
      end
    end
  end

  // Write response, error on unmapped address
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (doWrite) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wrHit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ****************************************************
  // Pointers and count
  // ****************************************************
  // Software write takes priority over the per-unit update
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      for (int c = 0; c < NUM_CH; c++) begin
        srcPtr[c] <= 32'h0000_0000;
        dstPtr[c] <= 32'h0000_0000;
        count[c] <= 16'h0000;
      end
    end else begin
      for (int c = 0; c < NUM_CH; c++) begin
        if (doWrite && wrHit && wrCh == 2'(c) && wrKind == 2'd0) begin
          srcPtr[c] <= merge(srcPtr[c], wrData, wrStrb);
        end else if (unitDone[c] && channelActive[c]
                     && ctl[c][RSEL_HI:RSEL_LO] != RS_EXT_DEV2MEM) begin
          srcPtr[c] <= stepPtr(srcPtr[c], ctl[c][SSTEP_HI:SSTEP_LO],
                               ctl[c][SIZE_BIT]);
        end
        if (doWrite && wrHit && wrCh == 2'(c) && wrKind == 2'd1) begin
          dstPtr[c] <= merge(dstPtr[c], wrData, wrStrb);
        end else if (unitDone[c] && channelActive[c]
                     && ctl[c][RSEL_HI:RSEL_LO] != RS_EXT_MEM2DEV) begin
          dstPtr[c] <= stepPtr(dstPtr[c], ctl[c][DSTEP_HI:DSTEP_LO],
                               ctl[c][SIZE_BIT]);
        end
        if (doWrite && wrHit && wrCh == 2'(c) && wrKind == 2'd2) begin
          count[c] <= 16'(merge({16'h0000, count[c]}, wrData, wrStrb));
        end else if (unitDone[c] && channelActive[c]) begin
          count[c] <= count[c] - 16'h0001;
        end
      end
    end
  end

  // ****************************************************
  // Control registers
  // ****************************************************
  // Clear on reset and standby; end flag set wins over clear
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      for (int c = 0; c < NUM_CH; c++) begin
        ctl[c] <= CTL_RESET;
      end
    end else if (standby) begin
      for (int c = 0; c < NUM_CH; c++) begin
        ctl[c] <= CTL_RESET;
      end
    end else begin
      for (int c = 0; c < NUM_CH; c++) begin
        logic [15:0] nv;
        logic endNow;
        nv = ctl[c];
        endNow = unitDone[c] && channelActive[c] && count[c] == 16'h0001;
        if (doWrite && wrHit && wrCh == 2'(c) && wrKind == 2'd3) begin
          nv = 16'(merge({16'h0000, ctl[c]}, wrData, wrStrb));
          nv[END_FLAG_BIT] = ctl[c][END_FLAG_BIT] & nv[END_FLAG_BIT];
          if (c >= EXT_CH) nv = nv & ~CTL_EXT_ONLY_MASK;
        end
        if (endNow) nv[END_FLAG_BIT] = 1'b1;
        ctl[c] <= nv;
      end
    end
  end

  // ****************************************************
  // Read channel
  // ****************************************************
  assign s_axi_arready = !s_axi_rvalid;
  assign {rdHit, rdCh, rdKind} = decode(s_axi_araddr);

  // Return register contents one cycle after the address is taken
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= rdHit ? RESP_OKAY : RESP_SLVERR;
      if (!rdHit) begin
        s_axi_rdata <= 32'h0000_0000;
      end else begin
        unique case (rdKind)
          2'd0: s_axi_rdata <= srcPtr[rdCh];
          2'd1: s_axi_rdata <= dstPtr[rdCh];
          2'd2: s_axi_rdata <= {16'h0000, count[rdCh]};
          2'd3: s_axi_rdata <= {16'h0000, ctl[rdCh]};
        endcase
      end
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ****************************************************
  // Request selection and status outputs
  // ****************************************************
  // Previous pin sample for falling-edge detection
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      extPrev <= 2'b11;
    end else begin
      extPrev <= ext_request_pin;
    end
  end

  // Per-channel decode of mode and request source
  always_comb begin
    for (int c = 0; c < NUM_CH; c++) begin
      logic [3:0] rs;
      logic req;
      logic extReq;
      req = 1'b0;
      rs = ctl[c][RSEL_HI:RSEL_LO];
      extReq = 1'b0;
      if (c < EXT_CH) begin
        extReq = ctl[c][REQ_DET_BIT] ? (extPrev[c] && !ext_request_pin[c])
                                     : !ext_request_pin[c];
      end
      unique case (rs)
        RS_EXT_DUAL, RS_EXT_MEM2DEV, RS_EXT_DEV2MEM: req = extReq;
        RS_SER0_RX: req = serial0_rx_full_req;
        RS_SER0_RX + 4'h1: req = serial0_tx_empty_req;
        RS_SER0_RX + 4'h2: req = serial1_rx_full_req;
        RS_SER0_RX + 4'h3: req = serial1_tx_empty_req;
        RS_TIMER0, RS_TIMER0 + 4'h1, RS_TIMER0 + 4'h2, RS_TIMER0 + 4'h3:
          req = timer_match_req[rs[1:0]];
        RS_AUTO: req = 1'b1;
        RS_CONV_END: req = conversion_end_req;
        default: req = 1'b0;
      endcase
      channelActive[c] = ctl[c][ENABLE_BIT] && !ctl[c][END_FLAG_BIT]
                         && global_dma_enable;
      channelRequest[c] = channelActive[c] && req;
      singleAddr[c] = (c < EXT_CH) && (rs == RS_EXT_MEM2DEV || rs == RS_EXT_DEV2MEM);
      burstMode[c] = ctl[c][BUS_MODE_BIT];
      wordSize[c] = ctl[c][SIZE_BIT];
      endIrq[c] = ctl[c][IRQ_EN_BIT] && ctl[c][END_FLAG_BIT];
      srcPointers[c*32 +: 32] = srcPtr[c];
      dstPointers[c*32 +: 32] = dstPtr[c];
    end
  end

  // Acknowledge pins: timing bit in dual mode, any access in single mode
  always_comb begin
    for (int c = 0; c < 2; c++) begin
      logic ack;
      ack = 1'b0;
      if (singleAddr[c]) begin
        ack = readCycle[c] || writeCycle[c];
      end else begin
        ack = ctl[c][ACK_TIMING_BIT] ? writeCycle[c] : readCycle[c];
      end
      ext_acknowledge_pin[c] = ack ^ ctl[c][ACK_POL_BIT];
    end
  end

endmodule
`default_nettype wire

// ### design/dma_chan_pkg.sv
// Package with register map, field layout and encodings of the DMA channel register block
package dma_chan_pkg;

  // ****************************************************
  // Geometry
  // ****************************************************
  localparam int NUM_CH = 4;
  localparam int EXT_CH = 2;
  localparam int ADDR_W = 10;
  localparam int DATA_W = 32;

  // ****************************************************
  // Register indices (byte address is four times index)
  // ****************************************************
  localparam logic [7:0] SRC_IDX = 8'h40;
  localparam logic [7:0] DST_IDX = 8'h44;
  localparam logic [7:0] CNT_IDX = 8'h4A;
  localparam logic [7:0] CTL_IDX = 8'h4E;
  localparam logic [7:0] CH_STRIDE = 8'h10;

  // ****************************************************
  // Control register fields and reset value
  // ****************************************************
  localparam int DSTEP_HI = 15;
  localparam int DSTEP_LO = 14;
  localparam int SSTEP_HI = 13;
  localparam int SSTEP_LO = 12;
  localparam int RSEL_HI = 11;
  localparam int RSEL_LO = 8;
  localparam int ACK_TIMING_BIT = 7;
  localparam int ACK_POL_BIT = 6;
  localparam int REQ_DET_BIT = 5;
  localparam int BUS_MODE_BIT = 4;
  localparam int SIZE_BIT = 3;
  localparam int IRQ_EN_BIT = 2;
  localparam int END_FLAG_BIT = 1;
  localparam int ENABLE_BIT = 0;
  localparam logic [15:0] CTL_RESET = 16'h0000;
  localparam logic [15:0] CTL_EXT_ONLY_MASK = 16'h00E0;

  // ****************************************************
  // Step and request-source encodings
  // ****************************************************
  typedef enum logic [1:0] {STEP_HOLD, STEP_INC, STEP_DEC, STEP_BAD} step_t;
  localparam logic [3:0] RS_EXT_DUAL = 4'h0;
  localparam logic [3:0] RS_EXT_MEM2DEV = 4'h2;
  localparam logic [3:0] RS_EXT_DEV2MEM = 4'h3;
  localparam logic [3:0] RS_SER0_RX = 4'h4;
  localparam logic [3:0] RS_TIMER0 = 4'h8;
  localparam logic [3:0] RS_AUTO = 4'hC;
  localparam logic [3:0] RS_CONV_END = 4'hD;

  // ****************************************************
  // Bus responses
  // ****************************************************
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage

// ### dv/dma_regs_sva.sv
// Port-level assertion checker for the DMA channel register block
`timescale 1ns/100ps
`default_nettype none
module dma_regs_sva #(
  parameter int NUM_CH = 4 // Channels
) (
  input wire logic ref_clk, // Clock
  input wire logic rst, // Reset
  input wire logic standby, // Standby
  input wire logic s_axi_awvalid, // AW valid
  input wire logic s_axi_awready, // AW ready
  input wire logic s_axi_wvalid, // W valid
  input wire logic s_axi_wready, // W ready
  input wire logic s_axi_bvalid, // B valid
  input wire logic s_axi_bready, // B ready
  input wire logic s_axi_arvalid, // AR valid
  input wire logic s_axi_arready, // AR ready
  input wire logic s_axi_rvalid, // R valid
  input wire logic s_axi_rready, // R ready
  input wire logic [31:0] s_axi_rdata, // R data
  input wire logic [NUM_CH-1:0] unitDone, // Unit pulses
  input wire logic [NUM_CH-1:0] channelActive, // Active
  input wire logic [NUM_CH-1:0] wordSize, // Word size
  input wire logic [NUM_CH-1:0] endIrq, // End interrupt
  input wire logic [NUM_CH*32-1:0] srcPointers // Source pointers
);
  // ********
  // Clocking and write handshake steps
  // ********
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_wr_answer;
    !s_axi_bvalid ##1 s_axi_bvalid;
  endsequence
  // ********
  // Properties
  // ********
  a_wr_answer: assert property (s_wr_taken |=> s_wr_answer)
    else $error("write response late");
  a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  a_rd_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  a_b_release: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  a_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("address taken during read data");
  a_ptr_hold: assert property (s_axi_awready && !unitDone[0] |=>
    $stable(srcPointers[31:0]))
    else $error("source pointer moved without cause");
  a_standby_clear: assert property (standby |=>
    channelActive == '0 && endIrq == '0 && wordSize == '0)
    else $error("control not cleared by standby");
  a_end_block: assert property ((endIrq & channelActive) == '0)
    else $error("channel active with end flag");
endmodule
bind dma_channel_control_regs dma_regs_sva #(.NUM_CH(NUM_CH)) chk (
  .ref_clk, .rst, .standby, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .unitDone, .channelActive,
  .wordSize, .endIrq, .srcPointers
);
`default_nettype wire

// ### dv/dma_far_side.sv
// Far-side model: request pins and per-unit bus phases
`timescale 1ns/100ps
`default_nettype none
module dma_far_side (
  input wire logic ref_clk, // Clock
  input wire logic rst, // Reset
  input wire logic [3:0] run, // Bench lets a channel move units
  input wire logic [1:0] reqOn, // Bench asserts a request pin
  input wire logic slow, // Idle cycle after each unit
  input wire logic [3:0] channelRequest, // Request seen by block
  output logic [1:0] ext_request_pin, // Active low pins
  output logic [3:0] unitDone, // One pulse per unit
  output logic [1:0] readCycle, // Read phase
  output logic [1:0] writeCycle // Write phase
);
  logic [1:0] phase [4];
  // Pins idle high, low while requesting
  assign ext_request_pin = ~reqOn;
  // Unit runs idle, read, write, optional gap; starts only on request
  always_ff @(posedge ref_clk or posedge rst) begin
    for (int c = 0; c < 4; c++) begin
      if (rst) begin
        phase[c] <= 2'd0;
      end else if (phase[c] == 2'd0) begin
        phase[c] <= (run[c] && channelRequest[c]) ? 2'd1 : 2'd0;
      end else begin
        phase[c] <= (phase[c] == 2'd2 && !slow) ? 2'd0 : phase[c] + 2'd1;
      end
    end
  end
  // Unit completes at the end of its write phase
  always_comb begin
    for (int c = 0; c < 4; c++) begin
      unitDone[c] = phase[c] == 2'd2;
    end
    for (int c = 0; c < 2; c++) begin
      readCycle[c] = phase[c] == 2'd1;
      writeCycle[c] = phase[c] == 2'd2;
    end
  end
endmodule
`default_nettype wire

// ### dv/dma_channel_control_regs_test.sv
// Self-checking bench for the DMA channel register block
`timescale 1ns/100ps
`default_nettype none
module dma_channel_control_regs_test;
  import dma_chan_pkg::*;
  typedef struct {logic [9:0] a; logic [31:0] d; logic [31:0] e;} row_t;
  logic ref_clk, rst, standby, globalOn, periph, slow, amSel, polSel;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [9:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rv;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr, reqOn, readCycle, writeCycle;
  logic [1:0] ext_request_pin, ext_acknowledge_pin;
  logic [3:0] unitDone, channelActive, channelRequest, singleAddr, burstMode;
  logic [3:0] wordSize, endIrq, run;
  logic [127:0] srcPointers, dstPointers;
  int fails, check_count;
  row_t rows [5];
  dma_channel_control_regs dut (
    .ref_clk, .rst, .standby, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .global_dma_enable(globalOn), .ext_request_pin, .serial0_rx_full_req(periph),
    .serial0_tx_empty_req(periph), .serial1_rx_full_req(periph),
    .serial1_tx_empty_req(periph), .timer_match_req({4{periph}}),
    .conversion_end_req(periph), .unitDone, .readCycle, .writeCycle,
    .ext_acknowledge_pin, .channelActive, .channelRequest, .singleAddr, .burstMode,
    .wordSize, .endIrq, .srcPointers, .dstPointers
  );
  dma_far_side far (
    .ref_clk, .rst, .run, .reqOn, .slow, .channelRequest, .ext_request_pin,
    .unitDone, .readCycle, .writeCycle
  );
  // ********
  // Helpers
  // ********
  function automatic logic [9:0] ra(logic [7:0] idx, int c);
    return 10'((idx + 8'(c) * CH_STRIDE) * 4);
  endfunction
  task automatic chk(string n, logic [31:0] e, logic [31:0] s);
    check_count++;
    if (s !== e) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  // Write: address and data offered together, each released once taken
  task automatic wr(logic [9:0] a, logic [31:0] d);
    int n = 0;
    logic ta, tw, tb = 1'b0;
    @(posedge ref_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!tb && n < 40) begin
      @(negedge ref_clk);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      tb = s_axi_bvalid;
      rr = s_axi_bresp;
      n++;
      @(posedge ref_clk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      if (tb) s_axi_bready <= 1'b0;
    end
    chk("write answer", 32'h1, 32'(tb));
  endtask
  task automatic rd(logic [9:0] a);
    int n = 0;
    logic ta, tb = 1'b0;
    @(posedge ref_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!tb && n < 40) begin
      @(negedge ref_clk);
      ta = s_axi_arvalid && s_axi_arready;
      tb = s_axi_rvalid;
      rv = s_axi_rdata;
      rr = s_axi_rresp;
      n++;
      @(posedge ref_clk);
      if (ta) s_axi_arvalid <= 1'b0;
      if (tb) s_axi_rready <= 1'b0;
    end
    chk("read answer", 32'h1, 32'(tb));
  endtask
  task automatic rc(logic [9:0] a, string n, logic [31:0] e);
    rd(a);
    chk(n, e, rv);
  endtask
  // Let channel c move k units, checking acknowledge timing on channel 0
  task automatic units(int c, int k);
    int n = 0;
    int seen = 0;
    @(posedge ref_clk);
    run <= 4'(1 << c);
    while (seen < k && n < 200) begin
      @(negedge ref_clk);
      seen += int'(unitDone[c]);
      if (c == 0 && (readCycle[0] || writeCycle[0])) begin
        chk("ack", 32'((writeCycle[0] == amSel) ^ polSel), 32'(ext_acknowledge_pin[0]));
      end
      n++;
      @(posedge ref_clk);
    end
    run <= 4'h0;
    chk("units", k, seen);
  endtask
  task automatic print_verdict();
    $display("Checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // ********
  // Clock, watchdog and sequence
  // ********
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  initial begin
    repeat (20000) @(posedge ref_clk);
    chk("watchdog", 32'h0, 32'h1);
    print_verdict();
  end
  initial begin
    {rst, standby, globalOn, periph, slow, amSel, reqOn, run} = 12'h800;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    rows = '{'{ra(SRC_IDX, 0), 32'h1234_5678, 32'h1234_5678},
      '{ra(DST_IDX, 1), 32'hA5A5_0F0F, 32'hA5A5_0F0F},
      '{ra(CNT_IDX, 2), 32'hDEAD_0003, 32'h0000_0003},
      '{ra(CTL_IDX, 3), 32'h0000_00E0, 32'h0000_0000},
      '{ra(CTL_IDX, 0), 32'h0000_00E2, 32'h0000_00E0}};
    repeat (6) @(posedge ref_clk);
    rst <= 1'b0;
    rc(ra(CTL_IDX, 3), "ctl reset", 32'h0);
    chk("active reset", 32'h0, 32'(channelActive));
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      rc(rows[i].a, "row", rows[i].e);
    end
    wr(10'h3FC, 32'hFFFF_FFFF);
    chk("bad resp", 32'(RESP_SLVERR), 32'(rr));
    rc(10'h3FC, "bad data", 32'h0);
    wr(ra(CTL_IDX, 1), 32'h0000_0018);
    chk("word size", 32'h1, 32'(wordSize[1]));
    chk("burst", 32'h1, 32'(burstMode[1]));
    standby <= 1'b1;
    @(posedge ref_clk);
    standby <= 1'b0;
    rc(ra(CTL_IDX, 1), "ctl standby", 32'h0);
    // Dual auto transfer on channel 2: word steps, count ends it
    globalOn <= 1'b1;
    wr(ra(SRC_IDX, 2), 32'h0000_1000);
    wr(ra(DST_IDX, 2), 32'h0000_2000);
    wr(ra(CNT_IDX, 2), 32'h0000_0002);
    wr(ra(CTL_IDX, 2), 32'h0000_6C0D);
    units(2, 2);
    rc(ra(CNT_IDX, 2), "count", 32'h0);
    rc(ra(SRC_IDX, 2), "src", 32'h0000_0FFC);
    rc(ra(DST_IDX, 2), "dst", 32'h0000_2004);
    chk("dst port", 32'h0000_2004, dstPointers[95:64]);
    rc(ra(CTL_IDX, 2), "ctl end", 32'h0000_6C0F);
    chk("end irq", 32'h1, 32'(endIrq[2]));
    wr(ra(CTL_IDX, 2), 32'h0000_6C0F);
    chk("no restart", 32'h0, 32'(channelActive[2]));
    wr(ra(CTL_IDX, 2), 32'h0000_6C0C);
    rc(ra(CTL_IDX, 2), "end clear", 32'h0000_6C0C);
    // Single address on channel 1, count zero, slow far side
    slow <= 1'b1;
    reqOn <= 2'b10;
    wr(ra(SRC_IDX, 1), 32'h0000_0040);
    wr(ra(DST_IDX, 1), 32'h0000_0080);
    wr(ra(CNT_IDX, 1), 32'h0000_0000);
    wr(ra(CTL_IDX, 1), 32'h0000_5301);
    chk("single", 32'h1, 32'(singleAddr[1]));
    units(1, 3);
    rc(ra(CNT_IDX, 1), "count wrap", 32'h0000_FFFD);
    rc(ra(SRC_IDX, 1), "src held", 32'h0000_0040);
    rc(ra(DST_IDX, 1), "dst stepped", 32'h0000_0083);
    wr(ra(CTL_IDX, 1), 32'h0000_5300);
    wr(ra(CTL_IDX, 1), 32'h0000_5201);
    units(1, 1);
    rc(ra(SRC_IDX, 1), "src stepped", 32'h0000_0041);
    rc(ra(DST_IDX, 1), "dst held", 32'h0000_0083);
    wr(ra(CTL_IDX, 1), 32'h0);
    // Acknowledge timing on channel 0 in dual mode
    slow <= 1'b0;
    reqOn <= 2'b01;
    for (int am = 0; am < 4; am++) begin
      amSel = am[0];
      polSel = am[1];
      wr(ra(CNT_IDX, 0), 32'h0000_0001);
      wr(ra(CTL_IDX, 0), 32'h1 | 32'(am[0]) << 7 | 32'(am[1]) << 6);
      units(0, 1);
      wr(ra(CTL_IDX, 0), 32'h0);
    end
    // Falling-edge detection: a pin held low gives no request
    wr(ra(CTL_IDX, 0), 32'h0000_0021);
    chk("edge idle", 32'h0, 32'(channelRequest[0]));
    // Every request source on channel 3, with peripherals low then high
    reqOn <= 2'b11;
    for (int lv = 0; lv < 2; lv++) begin
      periph <= lv[0];
      for (int rs = 0; rs < 16; rs++) begin
        wr(ra(CTL_IDX, 3), 32'(rs << 8));
        wr(ra(CTL_IDX, 3), 32'(rs << 8 | 1));
        chk("route", 32'(rs == 12 || lv && rs > 3 && rs < 14), 32'(channelRequest[3]));
        wr(ra(CTL_IDX, 3), 32'(rs << 8));
      end
    end
    print_verdict();
  end
endmodule
`default_nettype wire
